// >>> verilog/fmd_pkg.sv
package fmd_pkg;

  // Instruction word and datapath widths.
  localparam int unsigned INSTR_W = 14;
  localparam int unsigned DATA_W  = 8;
  localparam int unsigned ADDR_W  = 7;

  // Opcode field positions.
  localparam int unsigned DEST_BIT = 7;

  // Upper six bits that mark the file-move opcode.
  localparam logic [5:0] OP_MOVE_FILE  = 6'h08;
  // Upper seven bits that mark the store-working opcode.
  localparam logic [6:0] OP_STORE_WORK = 7'h01;
  // Fixed word of the option-load opcode.
  localparam logic [13:0] OP_OPTION_LD = 14'h0062;

  // Values after reset.
  localparam logic [7:0] WORK_RESET   = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hFF;
  localparam logic       ZERO_RESET   = 1'b0;

  // Decoded instruction classes.
  typedef enum logic [1:0] {
    FMD_OTHER,
    FMD_MOVE_FILE,
    FMD_STORE_WORK,
    FMD_OPTION_LOAD
  } fmd_op_t;

  // Write request to the file register array.
  typedef struct packed {
    logic       en;
    logic [6:0] addr;
    logic [7:0] data;
  } fmd_fwr_t;

endpackage

// >>> verilog/fmd_core.sv
// Operation
// - Decode file-move opcode, bit 7 destination, 7-bit address; read source.
// - File-move with destination clear loads working register; file untouched.
// - File-move with destination set writes source back to same file.
// - File-move sets zero flag from moved value for both destinations.
// - Store-working opcode copies working register to file; flags unchanged.
module fmd_core (
  // Clock, reset and enable.
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire logic                clk_en,
  // Instruction issue.
  input  wire logic                instr_valid,
  input  wire logic [13:0]         instr,
  // File register read port.
  output logic      [6:0]          file_raddr,
  input  wire logic [7:0]          file_rdata,
  // File register write port.
  output fmd_pkg::fmd_fwr_t        file_wr_q,
  // Core state.
  output logic      [7:0]          work_q,
  output logic      [7:0]          option_q,
  output logic                     zero_q
);

  ////////////////////////////////////////////////////////////////////////////
  fmd_pkg::fmd_op_t op;
  logic             dest_file;
  logic [7:0]       src;

  // File address is read combinationally from the array in the same cycle.
  assign file_raddr = instr[6:0];
  assign src        = file_rdata;
  assign dest_file  = instr[fmd_pkg::DEST_BIT];

  // Classify the instruction word.
  always_comb begin
    op = fmd_pkg::FMD_OTHER;
    if (!instr_valid) begin
      op = fmd_pkg::FMD_OTHER;
    end else if (instr[13:8] == fmd_pkg::OP_MOVE_FILE) begin
      op = fmd_pkg::FMD_MOVE_FILE;
    end else if (instr[13:7] == fmd_pkg::OP_STORE_WORK) begin
      op = fmd_pkg::FMD_STORE_WORK;
    end else if (instr == fmd_pkg::OP_OPTION_LD) begin
      op = fmd_pkg::FMD_OPTION_LOAD;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Working register is loaded only by a file-move to the working register.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      work_q <= fmd_pkg::WORK_RESET;
    end else if (clk_en) begin
      if (op == fmd_pkg::FMD_MOVE_FILE && !dest_file) begin
        work_q <= src;
      end
    end
  end

  // Zero flag follows every file-move and nothing else here.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      zero_q <= fmd_pkg::ZERO_RESET;
    end else if (clk_en) begin
      if (op == fmd_pkg::FMD_MOVE_FILE) begin
        zero_q <= (src == 8'h00);
      end
    end
  end

  // Registered file write; a one-cycle pulse per writing instruction.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      file_wr_q <= '0;
    end else if (clk_en) begin
      file_wr_q.en   <= 1'b0;
      file_wr_q.addr <= instr[6:0];
      file_wr_q.data <= src;
      if (op == fmd_pkg::FMD_MOVE_FILE && dest_file) begin
        file_wr_q.en   <= 1'b1;
      end else if (op == fmd_pkg::FMD_STORE_WORK) begin
        file_wr_q.en   <= 1'b1;
        file_wr_q.data <= work_q;
      end
    end
  end

  // Option register is loaded from the working register.
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      option_q <= fmd_pkg::OPTION_RESET;
    end else if (clk_en) begin
      if (op == fmd_pkg::FMD_OPTION_LOAD) begin
        option_q <= work_q;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.
  // Each result but the file read address is judged at the next clock edge after its instruction is taken.

  // Enabled cycle carrying a file-move towards the working register.
  sequence s_move_w;
    clk_en && op == fmd_pkg::FMD_MOVE_FILE && !dest_file;
  endsequence

  // Enabled cycle carrying a file-move back into the file itself.
  sequence s_move_f;
    clk_en && op == fmd_pkg::FMD_MOVE_FILE && dest_file;
  endsequence

  // Enabled cycle carrying a store of the working register.
  sequence s_store;
    clk_en && op == fmd_pkg::FMD_STORE_WORK;
  endsequence

  // Enabled cycle carrying the option load.
  sequence s_option;
    clk_en && op == fmd_pkg::FMD_OPTION_LOAD;
  endsequence

  // Enabled cycle with nothing of this group, a no-op included.
  sequence s_other;
    clk_en && op == fmd_pkg::FMD_OTHER;
  endsequence

  // Cycle in which the low enable must hold every register still.
  sequence s_frozen;
    !clk_en;
  endsequence

  // Reset seen low at two edges, so the flops have surely been cleared.
  sequence s_reset_held;
    !reset_n ##1 !reset_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // A move to the working register loads it and raises no file write.
  a_move_to_work: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_move_w |=> work_q == $past(src) && !file_wr_q.en)
    else $error("Move to working register failed.");

  // A move back to the file writes the same address and keeps W.
  a_move_to_file: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_move_f |=> file_wr_q.en && file_wr_q.data == $past(src)
      && file_wr_q.addr == $past(instr[6:0]) && $stable(work_q))
    else $error("Move back to file failed.");

  // Either kind of move sets the zero flag from the moved value.
  a_zero_flag: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && op == fmd_pkg::FMD_MOVE_FILE |=>
      zero_q == ($past(src) == 8'h00))
    else $error("Zero flag not set from moved value.");

  // The raw opcode bits alone must lead to a file read and a zero update.
  a_decode_move: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && instr_valid && instr[13:8] == fmd_pkg::OP_MOVE_FILE |->
      file_raddr == instr[6:0] ##1 zero_q == ($past(file_rdata) == 8'h00))
    else $error("File-move not decoded.");

  // A store writes W to the addressed file and leaves the zero flag alone.
  a_store_work: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_store |=> file_wr_q.en && file_wr_q.data == $past(work_q)
      && file_wr_q.addr == $past(instr[6:0]) && $stable(zero_q))
    else $error("Store of working register failed.");

  // The option load copies W, keeps the zero flag and writes no file.
  a_option_load: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_option |=> option_q == $past(work_q) && $stable(zero_q)
      && !file_wr_q.en)
    else $error("Option load failed.");

  // The store opcode bits alone must lead to a write of W.
  a_decode_store: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && instr_valid && instr[13:7] == fmd_pkg::OP_STORE_WORK |=>
      file_wr_q.en && file_wr_q.data == $past(work_q))
    else $error("Store-working opcode not decoded.");

  // The fixed option word alone must lead to the option load.
  a_decode_option: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && instr_valid && instr == fmd_pkg::OP_OPTION_LD |=>
      option_q == $past(work_q))
    else $error("Option-load opcode not decoded.");

  // The write strobe falls after any enabled cycle that writes nothing.
  a_write_pulse: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && op != fmd_pkg::FMD_STORE_WORK
      && !(op == fmd_pkg::FMD_MOVE_FILE && dest_file) |=> !file_wr_q.en)
    else $error("File write strobe held too long.");

  // W is only ever loaded by a move towards the working register.
  a_work_hold: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && !(op == fmd_pkg::FMD_MOVE_FILE && !dest_file) |=>
      $stable(work_q))
    else $error("Working register changed unexpectedly.");

  // No instruction but a file-move touches the zero flag.
  a_zero_hold: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && op != fmd_pkg::FMD_MOVE_FILE |=> $stable(zero_q))
    else $error("Zero flag changed unexpectedly.");

  // No instruction but the option load touches the option register.
  a_option_hold: assert property (
    @(posedge mclk) disable iff (!reset_n)
    clk_en && op != fmd_pkg::FMD_OPTION_LOAD |=> $stable(option_q))
    else $error("Option register changed unexpectedly.");

  // Foreign opcodes and idle cycles leave W, the zero flag and the option register as they were, and raise no file write.
  a_other_quiet: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_other |=> $stable(work_q) && $stable(zero_q) && $stable(option_q)
      && !file_wr_q.en)
    else $error("Foreign opcode changed state.");

  // A low enable freezes every register, the write request included.
  a_freeze_state: assert property (
    @(posedge mclk) disable iff (!reset_n)
    s_frozen |=> $stable(work_q) && $stable(zero_q) && $stable(option_q)
      && $stable(file_wr_q))
    else $error("State moved while the enable was low.");

  // A held reset leaves every register at its value after reset.
  a_reset_state: assert property (
    @(posedge mclk)
    s_reset_held |-> work_q == fmd_pkg::WORK_RESET
      && option_q == fmd_pkg::OPTION_RESET
      && zero_q == fmd_pkg::ZERO_RESET && !file_wr_q.en)
    else $error("Register not at its reset value.");

endmodule // fmd_core

// >>> sim/tb_fmd_core.sv
module tb_fmd_core;
  timeunit 1ns;
  timeprecision 100ps;
  ////////////////////////////////////////////////////////////////////////////
  logic              mclk = 1'b0;
  logic              reset_n = 1'b0;
  logic              clk_en = 1'b1;
  logic              instr_valid = 1'b0;
  logic [13:0]       instr = 14'h0000;
  logic [6:0]        file_raddr;
  logic [7:0]        file_rdata;
  logic [7:0]        work_q;
  logic [7:0]        option_q;
  logic              zero_q;
  fmd_pkg::fmd_fwr_t file_wr_q;
  int                n_mismatch = 0;
  int                compares = 0;

  // Clock generator, 10 ns period.
  always #5 mclk = ~mclk;

  // File array stand-in: address 0 reads as zero, others as twice the address.
  assign file_rdata = {file_raddr, 1'b0};

  fmd_core DUT (.mclk(mclk), .reset_n(reset_n), .clk_en(clk_en),
    .instr_valid(instr_valid), .instr(instr), .file_raddr(file_raddr),
    .file_rdata(file_rdata), .file_wr_q(file_wr_q), .work_q(work_q),
    .option_q(option_q), .zero_q(zero_q));
  ////////////////////////////////////////////////////////////////////////////
  // Compares one observed value with its expectation.
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Issues one instruction and lets its result land.
  task automatic run(input logic [13:0] i);
    @(posedge mclk);
    instr <= i;
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
  endtask

  // Prints the verdict and ends the run.
  task automatic tally_and_finish;
    if (n_mismatch == 0 && compares > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Moves file values into the working register, nonzero then zero.
  task automatic move_to_work;
    run(14'h0835);
    chk(file_raddr, 7'h35);
    chk({work_q, zero_q, file_wr_q.en}, {8'h6A, 2'b00});
    run(14'h0800);
    chk({work_q, zero_q}, {8'h00, 1'b1});
  endtask

  // Writes a file value back to itself; the write strobe lasts one cycle.
  task automatic move_to_file;
    run(14'h08C1);
    chk(file_wr_q, {1'b1, 7'h41, 8'h82});
    chk(work_q, 8'h00);
    chk(zero_q, 1'b0);
    @(posedge mclk);
    #1;
    chk(file_wr_q.en, 1'b0);
  endtask

  // Stores and loads option right after updates, with zero flag set.
  task automatic store_and_option;
    run(14'h0812);
    run(14'h0880);
    run(14'h00D5);
    chk(file_wr_q, {1'b1, 7'h55, 8'h24});
    chk(zero_q, 1'b1);
    chk(option_q, 8'hFF);
    run(14'h0062);
    chk({option_q, zero_q, file_wr_q.en}, {8'h24, 2'b10});
  endtask

  // A move issued while the enable is low must change nothing.
  task automatic frozen_move;
    @(posedge mclk);
    clk_en <= 1'b0;
    run(14'h0800);
    chk({work_q, zero_q, file_wr_q.en}, {8'h24, 2'b10});
    @(posedge mclk);
    clk_en <= 1'b1;
  endtask

  // A move to W followed at once by a store must store the new W.
  task automatic back_to_back;
    @(posedge mclk);
    instr       <= 14'h0810;
    instr_valid <= 1'b1;
    @(posedge mclk);
    instr       <= 14'h0091;
    @(posedge mclk);
    instr_valid <= 1'b0;
    #1;
    chk(file_wr_q, {1'b1, 7'h11, 8'h20});
    chk({work_q, zero_q}, {8'h20, 1'b0});
  endtask

  // Resets in mid-run, checks the reset values, then runs again.
  task automatic reset_mid;
    @(posedge mclk);
    reset_n <= 1'b0;
    @(posedge mclk);
    #1;
    chk({option_q, work_q}, 16'hFF00);
    chk({zero_q, file_wr_q.en}, 2'b00);
    @(posedge mclk);
    reset_n <= 1'b1;
    run(14'h0062);
    chk(option_q, 8'h00);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  // Main sequence after a four-cycle reset.
  initial begin
    repeat (4) @(posedge mclk);
    reset_n <= 1'b1;
    move_to_work();
    move_to_file();
    store_and_option();
    frozen_move();
    back_to_back();
    reset_mid();
    tally_and_finish();
  end

  // Watchdog against a hang.
  initial begin
    #5000;
    n_mismatch++;
    tally_and_finish();
  end
endmodule // tb_fmd_core
